// ### logic/srpt_status.sv
`timescale 1ns/1ps
`default_nettype none
module srpt_status
    import srpt_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            nrst_i,
    input  wire logic            optical_power_low_i,
    input  wire logic            optical_power_high_i,
    input  wire logic            motor_speed_low_i,
    input  wire logic            motor_speed_high_i,
    input  wire logic            std_event_summary_i,
    input  wire logic            response_waiting_i,
    input  wire logic [NEVT-1:0] err_evt_i,
    input  wire logic            cmd_valid_i,
    input  wire srpt_cmd_type    cmd_sel_i,
    input  wire logic [15:0]     cmd_data_i,
    output logic                 rsp_valid_o,
    output logic [15:0]          rsp_data_o,
    output logic [5:0]           rsp_text_idx_o,
    output logic [7:0]           status_byte_o,
    output logic                 srq_o
);

    function automatic logic [QPTR_W-1:0] ptr_inc(input logic [QPTR_W-1:0] p);
        ptr_inc = (p == QPTR_W'(QDEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    function automatic logic [QPTR_W-1:0] ptr_dec(input logic [QPTR_W-1:0] p);
        ptr_dec = (p == '0) ? QPTR_W'(QDEPTH - 1) : p - 1'b1;
    endfunction

    // position of a code in the description table
    function automatic logic [5:0] text_idx(input logic [7:0] c);
        logic [7:0] t;
        t = 8'h00;
        if (c <= 8'h07) t = c;
        else if (c == 8'h0D) t = 8'h08;
        else if (c >= 8'h28 && c <= 8'h2B) t = c - 8'h1F;
        else if (c == 8'h32) t = 8'h0D;
        else if (c >= 8'h3C && c <= 8'h43) t = c - 8'h2E;
        else if (c >= 8'h46 && c <= 8'h48) t = c - 8'h30;
        else if (c == 8'h50) t = 8'h19;
        else if (c == 8'h64 || c == 8'h65) t = c - 8'h4A;
        else if (c == 8'h6E || c == 8'h6F) t = c - 8'h52;
        else if (c >= 8'h7B && c <= 8'h7E) t = c - 8'h5D;
        else if (c >= 8'h82 && c <= 8'h85) t = c - 8'h60;
        text_idx = t[5:0];
    endfunction

    function automatic logic [7:0] evt_code(input logic [NEVT-1:0] g);
        logic [7:0] c;
        c = CODE_NONE;
        for (int i = 0; i < NEVT; i++) begin
            if (g[i]) c = c | EVT_CODE[i];
        end
        evt_code = c;
    endfunction

    logic [15:0]       err_cnd;
    logic [15:0]       err_cnd_ff;
    logic [15:0]       err_evt_ff;
    logic [15:0]       err_ena_ff;
    logic [15:0]       op_cnd;
    logic [15:0]       op_cnd_ff;
    logic [15:0]       op_evt_ff;
    logic [15:0]       op_ena_ff;
    logic [7:0]        sre_ff;
    logic [7:0]        nxt_sb;
    logic [NEVT-1:0]   pend_ff;
    logic [NEVT-1:0]   grant;
    logic              push;
    logic [7:0]        push_code;
    logic [7:0]        qmem [QDEPTH];
    logic [QPTR_W-1:0] wr_ptr_ff;
    logic [QPTR_W-1:0] rd_ptr_ff;
    logic [QPTR_W-1:0] cnt_ff;
    logic              full;
    logic              pop;
    logic [7:0]        head;
    logic              rd_err_evt;
    logic              rd_op_evt;

    assign err_cnd = {12'h000, optical_power_low_i, optical_power_high_i,
                      motor_speed_low_i, motor_speed_high_i} & ERR_USED_MASK;
    // every operation bit is reserved, so its condition is tied low
    assign op_cnd     = REG_RST & OPER_USED_MASK;
    assign rd_err_evt = cmd_valid_i && (cmd_sel_i == CMD_ERR_EVT);
    assign rd_op_evt  = cmd_valid_i && (cmd_sel_i == CMD_OPER_EVT);

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            err_cnd_ff <= REG_RST;
            op_cnd_ff  <= REG_RST;
        end else begin
            err_cnd_ff <= err_cnd;
            op_cnd_ff  <= op_cnd;
        end
    end

    // reading an event register clears it, but a fresh edge in that cycle survives
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            err_evt_ff <= REG_RST;
            op_evt_ff  <= REG_RST;
        end else begin
            err_evt_ff <= (rd_err_evt ? REG_RST : err_evt_ff) | (err_cnd ^ err_cnd_ff);
            op_evt_ff  <= (rd_op_evt ? REG_RST : op_evt_ff) | (op_cnd ^ op_cnd_ff);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            err_ena_ff <= REG_RST;
            op_ena_ff  <= REG_RST;
            sre_ff     <= 8'h00;
        end else if (cmd_valid_i) begin
            if (cmd_sel_i == CMD_ERR_SET) err_ena_ff <= cmd_data_i & ERR_USED_MASK;
            if (cmd_sel_i == CMD_OPER_SET) op_ena_ff <= cmd_data_i & OPER_USED_MASK;
            if (cmd_sel_i == CMD_SRE_SET) sre_ff <= cmd_data_i[7:0] & ~SB_RSVD_MASK;
        end
    end

    always_comb begin
        nxt_sb         = 8'h00;
        nxt_sb[SB_STD_EVT]  = std_event_summary_i;
        nxt_sb[SB_RSP_WAIT] = response_waiting_i;
        nxt_sb[SB_DES]      = |(err_evt_ff & err_ena_ff);
        nxt_sb[SB_ERRQ_NE]  = (cnt_ff != '0);
        nxt_sb[SB_OPS_SUM]  = |(op_evt_ff & op_ena_ff);
        // summary bit itself is kept out of the enable mask
        nxt_sb[SB_SRQ_SUM]  = |(nxt_sb & sre_ff & ~(8'h01 << SB_SRQ_SUM));
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            status_byte_o <= 8'h00;
            srq_o         <= 1'b0;
        end else begin
            status_byte_o <= nxt_sb;
            srq_o         <= nxt_sb[SB_SRQ_SUM];
        end
    end

    // simultaneous sources are held and queued one per cycle, lowest first
    assign grant     = pend_ff & (~pend_ff + 1'b1);
    assign push      = |pend_ff;
    assign push_code = evt_code(grant);

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) pend_ff <= '0;
        else pend_ff <= (pend_ff & ~grant) | err_evt_i;
    end

    assign full = (cnt_ff == QPTR_W'(QDEPTH));
    assign pop  = cmd_valid_i && (cmd_sel_i == CMD_ERRQ) && (cnt_ff != '0);
    assign head = qmem[rd_ptr_ff];

    always_ff @(posedge mclk_i) begin
        if (push && (!full || pop)) qmem[wr_ptr_ff] <= push_code;
        else if (push) qmem[ptr_dec(wr_ptr_ff)] <= CODE_QOVF;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push && (!full || pop)) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (pop) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            if ((push && (!full || pop)) && !pop) cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !(push && (!full || pop))) cnt_ff <= cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rsp_valid_o    <= 1'b0;
            rsp_data_o     <= 16'h0000;
            rsp_text_idx_o <= 6'h00;
        end else begin
            rsp_valid_o    <= 1'b0;
            rsp_text_idx_o <= 6'h00;
            if (cmd_valid_i) begin
                rsp_valid_o <= 1'b1;
                case (cmd_sel_i)
                    CMD_ERR_CND:  rsp_data_o <= err_cnd_ff;
                    CMD_ERR_EVT:  rsp_data_o <= err_evt_ff;
                    CMD_ERR_ENA:  rsp_data_o <= err_ena_ff;
                    CMD_OPER_CND: rsp_data_o <= op_cnd_ff;
                    CMD_OPER_EVT: rsp_data_o <= op_evt_ff;
                    CMD_OPER_ENA: rsp_data_o <= op_ena_ff;
                    CMD_STB:      rsp_data_o <= {8'h00, status_byte_o};
                    CMD_SRE:      rsp_data_o <= {8'h00, sre_ff};
                    CMD_ERRQ: begin
                        rsp_data_o     <= {8'h00, pop ? head : CODE_NONE};
                        rsp_text_idx_o <= text_idx(pop ? head : CODE_NONE);
                    end
                    default: begin
                        rsp_valid_o <= 1'b0;
                        rsp_data_o  <= rsp_data_o;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_stb_queue_flag: assert property (##1 status_byte_o[SB_ERRQ_NE] == ($past(cnt_ff) != '0))
        else $error("queue flag bit wrong");
    a_stb_resp_wait: assert property (##1 status_byte_o[SB_RSP_WAIT] == $past(response_waiting_i))
        else $error("response waiting bit wrong");
    a_stb_std_event: assert property (##1 status_byte_o[SB_STD_EVT] == $past(std_event_summary_i))
        else $error("standard event bit wrong");
    a_stb_des: assert property (##1 status_byte_o[SB_DES] == $past(|(err_evt_ff & err_ena_ff)))
        else $error("device error summary wrong");
    a_rsvd_zero: assert property ((status_byte_o & SB_RSVD_MASK) == 8'h00 && op_evt_ff == 16'h0000
        && (err_evt_ff & ~ERR_USED_MASK) == 16'h0000) else $error("reserved bit set");
    a_rqs_sum: assert property (srq_o == status_byte_o[SB_SRQ_SUM])
        else $error("service request mismatch");
    a_pwr_low_edge: assert property ($changed(optical_power_low_i) |=> err_evt_ff[ERR_PWR_LOW])
        else $error("optical low edge not latched");
    a_spd_high_edge: assert property ($changed(motor_speed_high_i) |=> err_evt_ff[ERR_SPD_HIGH])
        else $error("motor fast edge not latched");
    a_any_edge: assert property ((err_cnd ^ err_cnd_ff) != '0 |=>
        (err_evt_ff & $past(err_cnd ^ err_cnd_ff)) == $past(err_cnd ^ err_cnd_ff))
        else $error("error edge not latched");
    a_q_cap: assert property (cnt_ff <= QPTR_W'(QDEPTH))
        else $error("queue count above depth");
    a_pop_head: assert property (pop |=> rsp_valid_o && rsp_data_o[7:0] == $past(head))
        else $error("popped entry wrong");
    a_empty_zero: assert property (cmd_valid_i && cmd_sel_i == CMD_ERRQ && cnt_ff == '0 |=>
        rsp_data_o == 16'h0000 && rsp_text_idx_o == 6'h00) else $error("empty queue answer not zero");
    a_q_ovf: assert property (push && full && !pop |=> cnt_ff == QPTR_W'(QDEPTH)
        && qmem[ptr_dec(wr_ptr_ff)] == CODE_QOVF) else $error("overflow mark missing");

    c_overflow: cover property (push && full && !pop);
    c_pop: cover property (pop ##1 rsp_valid_o);
    c_edge_srq: cover property ($rose(optical_power_high_i) ##[1:4] srq_o);
    c_q_drain: cover property (cnt_ff == 5'h02 ##[1:20] cnt_ff == 5'h00);

endmodule // srpt_status
`default_nettype wire

// ### logic/srpt_pkg.sv
`default_nettype none
package srpt_pkg;
    // summary status byte bit positions
    localparam int SB_OPS_SUM  = 1;
    localparam int SB_ERRQ_NE  = 2;
    localparam int SB_DES      = 3;
    localparam int SB_RSP_WAIT = 4;
    localparam int SB_STD_EVT  = 5;
    localparam int SB_SRQ_SUM  = 6;
    localparam logic [7:0] SB_RSVD_MASK = 8'h81;
    // device error condition bit positions
    localparam int ERR_SPD_HIGH = 0;
    localparam int ERR_SPD_LOW  = 1;
    localparam int ERR_PWR_HIGH = 2;
    localparam int ERR_PWR_LOW  = 3;
    localparam logic [15:0] ERR_USED_MASK = 16'h000F;
    localparam logic [15:0] OPER_USED_MASK = 16'h0000;
    localparam logic [15:0] REG_RST = 16'h0000;
    // error queue
    localparam int QDEPTH = 30;
    localparam int QPTR_W = 5;
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_QOVF = 8'h3C;
    // error event sources, one strobe each, codes in source order
    localparam int NEVT = 20;
    localparam logic [7:0] EVT_CODE [NEVT] = '{
        8'h3D, 8'h3E, 8'h3F,                // command overflow, unknown, param count
        8'h40, 8'h41, 8'h42, 8'h43,         // bad decimal, nondecimal, string, char
        8'h32,                              // response buffer overflow
        8'h28, 8'h29, 8'h2A, 8'h2B,         // nv memory timeout, checksum, unknown, space
        8'h82, 8'h83, 8'h84, 8'h85,         // i2c start/stop, nack, short write, arb lost
        8'h64, 8'h65,                       // authentication needed, failed
        8'h6E, 8'h6F                        // service mode forbidden, required
    };
    typedef enum logic [3:0] {
        CMD_ERR_CND  = 4'h0,
        CMD_ERR_EVT  = 4'h1,
        CMD_ERR_ENA  = 4'h2,
        CMD_ERR_SET  = 4'h3,
        CMD_OPER_CND = 4'h4,
        CMD_OPER_EVT = 4'h5,
        CMD_OPER_ENA = 4'h6,
        CMD_OPER_SET = 4'h7,
        CMD_STB      = 4'h8,
        CMD_SRE      = 4'h9,
        CMD_SRE_SET  = 4'hA,
        CMD_ERRQ     = 4'hB
    } srpt_cmd_type;
endpackage
`default_nettype wire

// ### bench/srpt_host.sv
`timescale 1ns/1ps
`default_nettype none
module srpt_host
    import srpt_pkg::*;
(
    input  wire logic        mclk_i,
    output logic             cmd_valid_o,
    output srpt_cmd_type     cmd_sel_o,
    output logic [15:0]      cmd_data_o,
    input  wire logic        rsp_valid_i,
    input  wire logic [15:0] rsp_data_i,
    input  wire logic [5:0]  rsp_text_idx_i
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_sel_o   = CMD_STB;
        cmd_data_o  = 16'h0000;
    end
    // one command, answer sampled one edge after it is taken
    task automatic issue(input srpt_cmd_type sel, input logic [15:0] data,
                         output logic got, output logic [15:0] val, output logic [5:0] idx);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_sel_o   <= sel;
        cmd_data_o  <= data;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        // released data must not keep looking valid
        cmd_data_o  <= ~data;
        @(posedge mclk_i);
        got = rsp_valid_i;
        val = rsp_data_i;
        idx = rsp_text_idx_i;
    endtask
endmodule // srpt_host
`default_nettype wire

// ### bench/srpt_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module srpt_status_tb_top;
    import srpt_pkg::*;
    logic         mclk_i, nrst_i, pwr_lo, pwr_hi, spd_lo, spd_hi, ses, rwt, cmd_valid, rsp_valid, srq;
    logic [19:0]  err_evt;
    srpt_cmd_type cmd_sel;
    logic [15:0]  cmd_data, rsp_data;
    logic [5:0]   rsp_idx, last_idx;
    logic [7:0]   status;
    int           fail_count, checks;
    localparam logic [7:0] EXP_CODE [20] = '{8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h32, 8'h28,
        8'h29, 8'h2A, 8'h2B, 8'h82, 8'h83, 8'h84, 8'h85, 8'h64, 8'h65, 8'h6E, 8'h6F};
    localparam logic [5:0] EXP_IDX [20] = '{6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h0D, 6'h09,
        6'h0A, 6'h0B, 6'h0C, 6'h22, 6'h23, 6'h24, 6'h25, 6'h1A, 6'h1B, 6'h1C, 6'h1D};

    srpt_status srpt_status_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .optical_power_low_i(pwr_lo),
        .optical_power_high_i(pwr_hi), .motor_speed_low_i(spd_lo), .motor_speed_high_i(spd_hi),
        .std_event_summary_i(ses), .response_waiting_i(rwt), .err_evt_i(err_evt), .cmd_valid_i(cmd_valid),
        .cmd_sel_i(cmd_sel), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .rsp_text_idx_o(rsp_idx), .status_byte_o(status), .srq_o(srq));
    srpt_host srpt_host_i (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_sel_o(cmd_sel),
        .cmd_data_o(cmd_data), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .rsp_text_idx_i(rsp_idx));

    task automatic complete_run();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // set selects must stay silent, queries answer with want
    task automatic cmd(input srpt_cmd_type s, input logic [15:0] d, input logic ans, input logic [15:0] want);
        logic        got;
        logic [15:0] val;
        srpt_host_i.issue(s, d, got, val, last_idx);
        chk({15'h0000, got}, {15'h0000, ans});
        if (ans) chk(val, want);
    endtask

    task automatic t_reset();
        chk({8'h00, status}, 16'h0000);
        cmd(CMD_ERRQ, 16'h0000, 1'b1, 16'h0000);
        chk({10'h000, last_idx}, 16'h0000);
        cmd(CMD_OPER_CND, 16'h0000, 1'b1, 16'h0000);
        cmd(CMD_OPER_EVT, 16'h0000, 1'b1, 16'h0000);
        cmd(CMD_OPER_SET, 16'hFFFF, 1'b0, 16'h0000);
        cmd(CMD_OPER_ENA, 16'h0000, 1'b1, 16'h0000);
    endtask
    task automatic t_cond();
        cmd(CMD_ERR_SET, 16'hFFFF, 1'b0, 16'h0000);
        cmd(CMD_ERR_ENA, 16'h0000, 1'b1, 16'h000F);
        cmd(CMD_SRE_SET, 16'h0008, 1'b0, 16'h0000);
        {pwr_lo, pwr_hi, spd_lo, spd_hi} <= 4'hF;
        tick(4);
        chk({8'h00, status}, 16'h0048);
        chk({15'h0000, srq}, 16'h0001);
        cmd(CMD_STB, 16'h0000, 1'b1, 16'h0048);
        cmd(CMD_ERR_CND, 16'h0000, 1'b1, 16'h000F);
        cmd(CMD_ERR_EVT, 16'h0000, 1'b1, 16'h000F);
        tick(2);
        chk({8'h00, status}, 16'h0000);
        spd_lo <= 1'b0;
        tick(3);
        cmd(CMD_ERR_EVT, 16'h0000, 1'b1, 16'h0002);
        cmd(CMD_ERR_CND, 16'h0000, 1'b1, 16'h000D);
        {pwr_lo, pwr_hi, spd_lo, spd_hi} <= 4'h0;
        tick(3);
        cmd(CMD_ERR_EVT, 16'h0000, 1'b1, 16'h000D);
    endtask
    task automatic t_summary();
        ses <= 1'b1;
        rwt <= 1'b1;
        tick(3);
        chk({8'h00, status}, 16'h0030);
        // reserved enable bits 7 and 0 must not stick
        cmd(CMD_SRE_SET, 16'h00A1, 1'b0, 16'h0000);
        cmd(CMD_SRE, 16'h0000, 1'b1, 16'h0020);
        tick(2);
        chk({8'h00, status}, 16'h0070);
        ses <= 1'b0;
        rwt <= 1'b0;
        tick(3);
        chk({8'h00, status}, 16'h0000);
    endtask
    task automatic t_codes();
        err_evt <= 20'hFFFFF;
        tick(1);
        err_evt <= 20'h00000;
        tick(24);
        chk({8'h00, status}, 16'h0004);
        for (int i = 0; i < 20; i++) begin
            cmd(CMD_ERRQ, 16'h0000, 1'b1, {8'h00, EXP_CODE[i]});
            chk({10'h000, last_idx}, {10'h000, EXP_IDX[i]});
        end
        cmd(CMD_ERRQ, 16'h0000, 1'b1, 16'h0000);
        tick(2);
        chk({8'h00, status}, 16'h0000);
    endtask
    task automatic t_ovf();
        for (int i = 0; i < 31; i++) begin
            err_evt <= 20'h00002;
            tick(1);
            err_evt <= 20'h00000;
            tick(1);
        end
        tick(3);
        for (int i = 0; i < 29; i++) cmd(CMD_ERRQ, 16'h0000, 1'b1, 16'h003E);
        cmd(CMD_ERRQ, 16'h0000, 1'b1, 16'h003C);
        chk({10'h000, last_idx}, 16'h000E);
        cmd(CMD_ERRQ, 16'h0000, 1'b1, 16'h0000);
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        complete_run();
    end
    initial begin
        fail_count = 0;
        checks = 0;
        nrst_i = 1'b0;
        {pwr_lo, pwr_hi, spd_lo, spd_hi, ses, rwt} = 6'h00;
        err_evt = 20'h00000;
        tick(10);
        nrst_i <= 1'b1;
        t_reset();
        t_cond();
        t_summary();
        t_codes();
        t_ovf();
        complete_run();
    end
endmodule // srpt_status_tb_top
`default_nettype wire
